// ===== common/gpp_pkg.sv
// gpp_pkg: register map, reset values and carrier types of the eight-pin port
package gpp_pkg;
	localparam int unsigned PINS     = 8;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned DATA_W   = 32;
	// byte offsets; pin_value fills 0x000..0x3fc
	localparam logic [11:0] OFF_DIR  = 12'h400;
	localparam logic [11:0] OFF_IS   = 12'h404;
	localparam logic [11:0] OFF_IBE  = 12'h408;
	localparam logic [11:0] OFF_IEV  = 12'h40c;
	localparam logic [11:0] OFF_IM   = 12'h410;
	localparam logic [11:0] OFF_RIS  = 12'h414;
	localparam logic [11:0] OFF_MIS  = 12'h418;
	localparam logic [11:0] OFF_ICR  = 12'h41c;
	localparam logic [11:0] OFF_AFS  = 12'h420;
	localparam logic [11:0] OFF_DRL  = 12'h500;
	localparam logic [11:0] OFF_DRM  = 12'h504;
	localparam logic [11:0] OFF_DRH  = 12'h508;
	localparam logic [11:0] OFF_ODR  = 12'h50c;
	localparam logic [11:0] OFF_PUR  = 12'h510;
	localparam logic [11:0] OFF_PDR  = 12'h514;
	localparam logic [11:0] OFF_SLR  = 12'h518;
	localparam logic [11:0] OFF_DEN  = 12'h51c;
	localparam logic [11:0] OFF_PIDH = 12'hfd0; // peripheral ident words 4..7
	localparam logic [11:0] OFF_PIDL = 12'hfe0; // peripheral ident words 0..3
	localparam logic [11:0] OFF_CID  = 12'hff0; // component ident words 0..3
	// field positions
	localparam int unsigned MASK_LSB = 2;
	localparam int unsigned MASK_MSB = 9;
	// reset values
	localparam logic [7:0]  RST_ZERO = 8'h00;
	localparam logic [7:0]  RST_DRL  = 8'hff;
	localparam logic [7:0]  RST_PUR  = 8'hff;
	localparam logic [7:0]  RST_DEN  = 8'hff;
	// bus answers
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef enum logic [4:0] {
		SEL_DATA, SEL_DIR, SEL_IS, SEL_IBE, SEL_IEV, SEL_IM, SEL_RIS, SEL_MIS,
		SEL_ICR, SEL_AFS, SEL_DRL, SEL_DRM, SEL_DRH, SEL_ODR, SEL_PUR, SEL_PDR,
		SEL_SLR, SEL_DEN, SEL_PIDH, SEL_PIDL, SEL_CID, SEL_NONE
	} gpp_sel_t;

	// per-pin pad settings presented to the pad ring
	typedef struct packed {
		logic [7:0] drive_low_select;
		logic [7:0] drive_mid_select;
		logic [7:0] drive_high_select;
		logic [7:0] open_drain_select;
		logic [7:0] pull_up_select;
		logic [7:0] pull_down_select;
		logic [7:0] slew_control_select;
		logic [7:0] digital_input_enable;
	} gpp_pad_cfg_t;
endpackage : gpp_pkg

// ===== core/gpp_port.sv
// gpp_port: eight-pin port with masked data access, pad control and interrupts
//
// Contract
// - reset: pins are inputs, alt select 0, debug pins alt select 1
// - power-on or external reset restores every pin default
// - direction 0 captures pad level into pin_value; 1 drives pin_value out
// - pin_value accesses use address bits 9..2 as per-bit mask
// - pin_value decoded at 256 word locations, one per mask
// - masked write changes only bits whose mask bit is one
// - masked read returns zero for bits whose mask bit is zero
// - all pin interrupts combine into one port interrupt output
// - edge interrupt stays latched until software clears it
// - sense, both-edges and polarity choose each pin's trigger
// - sense 0 edge, 1 level; both 1; polarity 1 high or rising
// - mask gates forwarding only, never detection
// - raw status shows all conditions, masked status only enabled ones
// - writing one to clear bit clears latch; zero does nothing
// - unmasked interrupt on adc trigger pin also holds adc trigger high while its status stays set
// - trigger reconfiguration may raise a spurious interrupt
// - alt select set gives pin to peripheral, clear to software
// - drive, open-drain, pulls, slew and input enable held per pin
// - read-only peripheral and component ident words fixed at reset
// - every port is an identical instance of this block
// - unbonded pin bits ignore writes
`timescale 1ns/10ps
`default_nettype none
// one block for every port; per-port differences are parameters only
module gpp_port #(
	parameter logic [7:0]  AFSEL_RST    = 8'h00,       // debug pins per instance
	parameter logic [7:0]  BONDED       = 8'hff,       // pins with a pad
	parameter int unsigned ADC_PIN      = 4,
	parameter logic        ADC_TRIG_EN  = 1'b1,
	parameter logic [63:0] PERIPH_ID    = 64'h0706050403020100, // arbitrary value
	parameter logic [31:0] COMPONENT_ID = 32'h03020100          // arbitrary value
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic [7:0]           pad_in,
	output logic [7:0]                pad_out,
	output logic [7:0]                pad_oe,
	input  wire logic [7:0]           alt_out,
	input  wire logic [7:0]           alt_oe,
	output logic [7:0]                alt_in,
	output gpp_pkg::gpp_pad_cfg_t     pad_cfg,
	output logic                      irq,
	output logic                      adc_trigger
);
	// register offset decode, shared by the write and read paths
	function automatic gpp_pkg::gpp_sel_t decode(input logic [11:0] a);
		gpp_pkg::gpp_sel_t s;
		s = gpp_pkg::SEL_NONE;
		if (a[11:10] == 2'b00) s = gpp_pkg::SEL_DATA;
		else if (a[11:2] == gpp_pkg::OFF_DIR[11:2]) s = gpp_pkg::SEL_DIR;
		else if (a[11:2] == gpp_pkg::OFF_IS[11:2]) s = gpp_pkg::SEL_IS;
		else if (a[11:2] == gpp_pkg::OFF_IBE[11:2]) s = gpp_pkg::SEL_IBE;
		else if (a[11:2] == gpp_pkg::OFF_IEV[11:2]) s = gpp_pkg::SEL_IEV;
		else if (a[11:2] == gpp_pkg::OFF_IM[11:2]) s = gpp_pkg::SEL_IM;
		else if (a[11:2] == gpp_pkg::OFF_RIS[11:2]) s = gpp_pkg::SEL_RIS;
		else if (a[11:2] == gpp_pkg::OFF_MIS[11:2]) s = gpp_pkg::SEL_MIS;
		else if (a[11:2] == gpp_pkg::OFF_ICR[11:2]) s = gpp_pkg::SEL_ICR;
		else if (a[11:2] == gpp_pkg::OFF_AFS[11:2]) s = gpp_pkg::SEL_AFS;
		else if (a[11:2] == gpp_pkg::OFF_DRL[11:2]) s = gpp_pkg::SEL_DRL;
		else if (a[11:2] == gpp_pkg::OFF_DRM[11:2]) s = gpp_pkg::SEL_DRM;
		else if (a[11:2] == gpp_pkg::OFF_DRH[11:2]) s = gpp_pkg::SEL_DRH;
		else if (a[11:2] == gpp_pkg::OFF_ODR[11:2]) s = gpp_pkg::SEL_ODR;
		else if (a[11:2] == gpp_pkg::OFF_PUR[11:2]) s = gpp_pkg::SEL_PUR;
		else if (a[11:2] == gpp_pkg::OFF_PDR[11:2]) s = gpp_pkg::SEL_PDR;
		else if (a[11:2] == gpp_pkg::OFF_SLR[11:2]) s = gpp_pkg::SEL_SLR;
		else if (a[11:2] == gpp_pkg::OFF_DEN[11:2]) s = gpp_pkg::SEL_DEN;
		else if (a[11:4] == gpp_pkg::OFF_PIDH[11:4]) s = gpp_pkg::SEL_PIDH;
		else if (a[11:4] == gpp_pkg::OFF_PIDL[11:4]) s = gpp_pkg::SEL_PIDL;
		else if (a[11:4] == gpp_pkg::OFF_CID[11:4]) s = gpp_pkg::SEL_CID;
		return s;
	endfunction : decode
	// bit merge under a mask; unbonded pins never take a write
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
		input logic [7:0] msk);
		logic [7:0] m;
		m = msk & BONDED;
		return (old & ~m) | (val & m);
	endfunction : merge
	// bus state
	logic        aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
	logic        awready_r, awready_nxt, wready_r, wready_nxt;
	logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [11:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic        wstrb0_r, wstrb0_nxt;
	logic        wr_do;
	gpp_pkg::gpp_sel_t wsel, rsel;
	// register state
	logic [7:0]  data_r, data_nxt, dir_r, dir_nxt, is_r, is_nxt, ibe_r, ibe_nxt;
	logic [7:0]  iev_r, iev_nxt, im_r, im_nxt, ris_r, ris_nxt, afs_r, afs_nxt;
	gpp_pkg::gpp_pad_cfg_t cfg_r, cfg_nxt;
	logic [7:0]  clr, rise, fall, edge_evt, lvl_evt;
	// pad state
	logic [7:0]  sync1_r, sync2_r, prev_r, in_s;
	logic [7:0]  pad_out_r, pad_out_nxt, pad_oe_r, pad_oe_nxt, alt_in_r;
	logic [7:0]  drv_out, drv_oe;
	logic        irq_r, irq_nxt, adc_r, adc_nxt;
	logic [5:0]  cfg_lsb;
	// decodes; pad field position puts the word at 0x500 in the top byte
	assign wsel = decode(awaddr_r);
	assign rsel = decode(s_axi_araddr);
	assign wr_do = aw_full_r && w_full_r && !bvalid_r;
	assign cfg_lsb = {3'd7 - awaddr_r[4:2], 3'b000};
	// slave handshake: address and data caught in either order, answer one cycle later
	always_comb begin
		aw_full_nxt = aw_full_r;
		w_full_nxt  = w_full_r;
		awaddr_nxt  = awaddr_r;
		wdata_nxt   = wdata_r;
		wstrb0_nxt  = wstrb0_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		rvalid_nxt  = rvalid_r;
		rresp_nxt   = rresp_r;
		rdata_nxt   = rdata_r;
		if (s_axi_awvalid && awready_r) begin
			aw_full_nxt = 1'b1;
			awaddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r) begin
			w_full_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb0_nxt = s_axi_wstrb[0];
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (wr_do) begin
			aw_full_nxt = 1'b0;
			w_full_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = (wsel == gpp_pkg::SEL_NONE) ? gpp_pkg::RESP_SLVERR
				: gpp_pkg::RESP_OKAY;
		end
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = (rsel == gpp_pkg::SEL_NONE) ? gpp_pkg::RESP_SLVERR
				: gpp_pkg::RESP_OKAY;
			rdata_nxt  = 32'h0000_0000;
			case (rsel)
				gpp_pkg::SEL_DATA: rdata_nxt[7:0] = data_r
					& s_axi_araddr[gpp_pkg::MASK_MSB:gpp_pkg::MASK_LSB];
				gpp_pkg::SEL_DIR:  rdata_nxt[7:0] = dir_r;
				gpp_pkg::SEL_IS:   rdata_nxt[7:0] = is_r;
				gpp_pkg::SEL_IBE:  rdata_nxt[7:0] = ibe_r;
				gpp_pkg::SEL_IEV:  rdata_nxt[7:0] = iev_r;
				gpp_pkg::SEL_IM:   rdata_nxt[7:0] = im_r;
				gpp_pkg::SEL_RIS:  rdata_nxt[7:0] = ris_r;
				gpp_pkg::SEL_MIS:  rdata_nxt[7:0] = ris_r & im_r;
				gpp_pkg::SEL_AFS:  rdata_nxt[7:0] = afs_r;
				gpp_pkg::SEL_DRL:  rdata_nxt[7:0] = cfg_r.drive_low_select;
				gpp_pkg::SEL_DRM:  rdata_nxt[7:0] = cfg_r.drive_mid_select;
				gpp_pkg::SEL_DRH:  rdata_nxt[7:0] = cfg_r.drive_high_select;
				gpp_pkg::SEL_ODR:  rdata_nxt[7:0] = cfg_r.open_drain_select;
				gpp_pkg::SEL_PUR:  rdata_nxt[7:0] = cfg_r.pull_up_select;
				gpp_pkg::SEL_PDR:  rdata_nxt[7:0] = cfg_r.pull_down_select;
				gpp_pkg::SEL_SLR:  rdata_nxt[7:0] = cfg_r.slew_control_select;
				gpp_pkg::SEL_DEN:  rdata_nxt[7:0] = cfg_r.digital_input_enable;
				gpp_pkg::SEL_PIDH: rdata_nxt[7:0] = PERIPH_ID[{1'b1, s_axi_araddr[3:2], 3'b000} +: 8];
				gpp_pkg::SEL_PIDL: rdata_nxt[7:0] = PERIPH_ID[{1'b0, s_axi_araddr[3:2], 3'b000} +: 8];
				gpp_pkg::SEL_CID:  rdata_nxt[7:0] = COMPONENT_ID[{s_axi_araddr[3:2], 3'b000} +: 8];
				default:           rdata_nxt = 32'h0000_0000;
			endcase
		end
		awready_nxt = !aw_full_nxt;
		wready_nxt  = !w_full_nxt;
		arready_nxt = !rvalid_nxt;
	end

	// bus registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			arready_r <= 1'b0;
			bvalid_r  <= 1'b0;
			rvalid_r  <= 1'b0;
			bresp_r   <= gpp_pkg::RESP_OKAY;
			rresp_r   <= gpp_pkg::RESP_OKAY;
			awaddr_r  <= 12'h000;
			wdata_r   <= 32'h0000_0000;
			wstrb0_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			arready_r <= arready_nxt;
			bvalid_r  <= bvalid_nxt;
			rvalid_r  <= rvalid_nxt;
			bresp_r   <= bresp_nxt;
			rresp_r   <= rresp_nxt;
			awaddr_r  <= awaddr_nxt;
			wdata_r   <= wdata_nxt;
			wstrb0_r  <= wstrb0_nxt;
			rdata_r   <= rdata_nxt;
		end
	end
	assign in_s = sync2_r & cfg_r.digital_input_enable;
	// register writes, input capture and interrupt detection
	always_comb begin
		data_nxt = data_r;
		dir_nxt  = dir_r;
		is_nxt   = is_r;
		ibe_nxt  = ibe_r;
		iev_nxt  = iev_r;
		im_nxt   = im_r;
		afs_nxt  = afs_r;
		cfg_nxt  = cfg_r;
		clr      = 8'h00;
		// only byte lane 0 carries pin bits; other lanes are ignored
		if (wr_do && wstrb0_r) begin
			case (wsel)
				gpp_pkg::SEL_DATA: data_nxt = merge(data_r, wdata_r[7:0],
					awaddr_r[gpp_pkg::MASK_MSB:gpp_pkg::MASK_LSB]);
				gpp_pkg::SEL_DIR:  dir_nxt = merge(dir_r, wdata_r[7:0], 8'hff);
				// trigger settings act at once, no glitch suppression
				gpp_pkg::SEL_IS:   is_nxt = merge(is_r, wdata_r[7:0], 8'hff);
				gpp_pkg::SEL_IBE:  ibe_nxt = merge(ibe_r, wdata_r[7:0], 8'hff);
				gpp_pkg::SEL_IEV:  iev_nxt = merge(iev_r, wdata_r[7:0], 8'hff);
				gpp_pkg::SEL_IM:   im_nxt = merge(im_r, wdata_r[7:0], 8'hff);
				gpp_pkg::SEL_ICR:  clr = wdata_r[7:0] & BONDED;
				gpp_pkg::SEL_AFS:  afs_nxt = merge(afs_r, wdata_r[7:0], 8'hff);
				// pad settings; struct fields sit in offset order
				gpp_pkg::SEL_DRL, gpp_pkg::SEL_DRM, gpp_pkg::SEL_DRH, gpp_pkg::SEL_ODR,
				gpp_pkg::SEL_PUR, gpp_pkg::SEL_PDR, gpp_pkg::SEL_SLR, gpp_pkg::SEL_DEN:
					cfg_nxt[cfg_lsb +: 8] = merge(cfg_r[cfg_lsb +: 8], wdata_r[7:0], 8'hff);
				default: ;
			endcase
		end
		// input pins capture pad level, overriding any write
		data_nxt = (data_nxt & dir_r) | (in_s & ~dir_r & BONDED);
		// edges from current versus previous sample
		rise = in_s & ~prev_r;
		fall = ~in_s & prev_r;
		edge_evt = (ibe_r & (rise | fall)) | (~ibe_r & ((iev_r & rise) | (~iev_r & fall)));
		lvl_evt  = (iev_r & in_s) | (~iev_r & ~in_s);
		// edges latch until cleared, set beats clear; mask not involved
		ris_nxt = ((is_r & lvl_evt) | (~is_r & (edge_evt | (ris_r & ~clr)))) & BONDED;
		// one port interrupt from masked status
		irq_nxt = |(ris_nxt & im_nxt);
		// adc trigger follows the masked status of the trigger pin
		adc_nxt = ADC_TRIG_EN & ris_nxt[ADC_PIN] & im_nxt[ADC_PIN];
	end
	// reset defaults; the reset input carries both power-on and pin reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_r <= gpp_pkg::RST_ZERO;
			dir_r  <= gpp_pkg::RST_ZERO;
			is_r   <= gpp_pkg::RST_ZERO;
			ibe_r  <= gpp_pkg::RST_ZERO;
			iev_r  <= gpp_pkg::RST_ZERO;
			im_r   <= gpp_pkg::RST_ZERO;
			ris_r  <= gpp_pkg::RST_ZERO;
			afs_r  <= AFSEL_RST;
			cfg_r  <= '{gpp_pkg::RST_DRL, gpp_pkg::RST_ZERO, gpp_pkg::RST_ZERO,
				gpp_pkg::RST_ZERO, gpp_pkg::RST_PUR, gpp_pkg::RST_ZERO,
				gpp_pkg::RST_ZERO, gpp_pkg::RST_DEN};
			irq_r  <= 1'b0;
			adc_r  <= 1'b0;
		end else begin
			data_r <= data_nxt;
			dir_r  <= dir_nxt;
			is_r   <= is_nxt;
			ibe_r  <= ibe_nxt;
			iev_r  <= iev_nxt;
			im_r   <= im_nxt;
			ris_r  <= ris_nxt;
			afs_r  <= afs_nxt;
			cfg_r  <= cfg_nxt;
			irq_r  <= irq_nxt;
			adc_r  <= adc_nxt;
		end
	end
	// pin owner mux; open drain only ever pulls low
	always_comb begin
		drv_out     = (afs_r & alt_out) | (~afs_r & data_r);
		drv_oe      = ((afs_r & alt_oe) | (~afs_r & dir_r)) & BONDED;
		pad_out_nxt = drv_out & ~cfg_r.open_drain_select;
		pad_oe_nxt  = drv_oe & ~(cfg_r.open_drain_select & drv_out);
	end
	// pad synchroniser and drivers; sync1 feeds sync2 only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r   <= 8'h00;
			sync2_r   <= 8'h00;
			prev_r    <= 8'h00;
			pad_out_r <= 8'h00;
			pad_oe_r  <= 8'h00;
			alt_in_r  <= 8'h00;
		end else begin
			sync1_r   <= pad_in;
			sync2_r   <= sync1_r;
			prev_r    <= in_s;
			pad_out_r <= pad_out_nxt;
			pad_oe_r  <= pad_oe_nxt;
			alt_in_r  <= in_s;
		end
	end
	// outputs straight from their flip-flops
	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;
	assign pad_out       = pad_out_r;
	assign pad_oe        = pad_oe_r;
	assign alt_in        = alt_in_r;
	assign pad_cfg       = cfg_r;
	assign irq           = irq_r;
	assign adc_trigger   = adc_r;

	// checks on pin 0, the port interrupt, the adc trigger and the bus; reset masks them all
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_irq_or_mask: assert property (irq == |(ris_r & im_r))
		else $error("port interrupt differs from OR of masked status");
	chk_edge_latch_hold: assert property (ris_r[0] && !is_r[0] && !(wr_do && wstrb0_r
		&& wsel == gpp_pkg::SEL_ICR && wdata_r[0]) |=> ris_r[0])
		else $error("edge latch dropped without a clear");
	chk_clear_one_bit: assert property (wr_do && wstrb0_r && wsel == gpp_pkg::SEL_ICR
		&& wdata_r[0] && !is_r[0] && !edge_evt[0] && BONDED[0] |=> !ris_r[0])
		else $error("clear write left edge latch set");
	chk_data_masked_wr: assert property (wr_do && wstrb0_r && wsel == gpp_pkg::SEL_DATA
		&& awaddr_r[2] && dir_r[0] && BONDED[0] |=> data_r[0] == $past(wdata_r[0]))
		else $error("masked data write did not land");
	chk_data_keep_bit: assert property (wr_do && wsel == gpp_pkg::SEL_DATA && !awaddr_r[2]
		&& dir_r[0] |=> $stable(data_r[0]))
		else $error("unmasked data bit changed");
	chk_read_mask_zero: assert property (s_axi_arvalid && arready_r
		&& rsel == gpp_pkg::SEL_DATA && !s_axi_araddr[2] |=> rvalid_r && !rdata_r[0])
		else $error("masked-off data bit read non-zero");
	chk_input_capture: assert property (!dir_r[0] && BONDED[0]
		|=> data_r[0] == $past(in_s[0]))
		else $error("input pin did not capture pad level");
	chk_level_raw: assert property (is_r[0] && (iev_r[0] == in_s[0]) && BONDED[0] |=> ris_r[0])
		else $error("level condition missing from raw status");
	chk_sw_drive_pad: assert property (!afs_r[0] && dir_r[0] && !cfg_r.open_drain_select[0]
		&& BONDED[0] |=> pad_oe[0] && pad_out[0] == $past(data_r[0]))
		else $error("output pin not driving pin_value");
	chk_alt_owns_pad: assert property (afs_r[0] && !cfg_r.open_drain_select[0] && BONDED[0]
		|=> pad_oe[0] == $past(alt_oe[0]) && pad_out[0] == $past(alt_out[0]))
		else $error("peripheral does not own the pin");
	chk_adc_follow: assert property (adc_trigger |-> ADC_TRIG_EN && irq)
		else $error("adc trigger without port interrupt");
	chk_write_answer: assert property (wr_do |=> bvalid_r ##0 !aw_full_r)
		else $error("write not answered next cycle");
	cov_masked_write: cover property (wr_do && wsel == gpp_pkg::SEL_DATA ##1 bvalid_r);
	cov_edge_irq: cover property (!is_r[0] && im_r[0] && edge_evt[0] ##1 irq);
	cov_level_irq: cover property (is_r[0] && im_r[0] && ris_r[0] ##1 irq);
	cov_id_read: cover property (s_axi_arvalid && arready_r && rsel == gpp_pkg::SEL_CID);
endmodule : gpp_port
`default_nettype wire

// ===== testbench/gpp_pad_model.sv
// gpp_pad_model: pad ring and peripheral stand-in for one port
`timescale 1ns/10ps
`default_nettype none
module gpp_pad_model (
	input  wire logic [7:0]            pad_out,
	input  wire logic [7:0]            pad_oe,
	input  wire gpp_pkg::gpp_pad_cfg_t pad_cfg,
	input  wire logic [7:0]            ext_lvl,
	input  wire logic [7:0]            ext_en,
	output logic [7:0]                 pad_in,
	output logic [7:0]                 alt_out,
	output logic [7:0]                 alt_oe
);
	// level held
	// wire level: port drive, then outside driver, then pull; bench never fights the port
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_lvl[i];
			else
				pad_in[i] = pad_cfg.pull_up_select[i] & ~pad_cfg.pull_down_select[i];
		end
	end
	// peripheral idles: its enable stays low so the debug pin floats
	assign alt_out = 8'h00;
	assign alt_oe  = 8'h00;
endmodule : gpp_pad_model
`default_nettype wire

// ===== testbench/tb_top.sv
// tb_top: register-level bench of the eight-pin port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wr, bv, arr, rv, irq, adc;
	logic [11:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rdat;
	logic [1:0]  br, rr, rrsp, brsp;
	logic [7:0]  pin, pout, poe, aout, aoe, ain, ext = 8'h00, exen = 8'h00;
	gpp_pkg::gpp_pad_cfg_t cfg;
	int n_fail = 0, cmp_count = 0;
	always #5 aclk = ~aclk;
	// component ident value is arbitrary, chosen so read-back differs from the default
	gpp_port #(.AFSEL_RST(8'h80), .COMPONENT_ID(32'h0d0c0b0a)) i_gpp_port (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry), .pad_in(pin), .pad_out(pout), .pad_oe(poe), .alt_out(aout),
		.alt_oe(aoe), .alt_in(ain), .pad_cfg(cfg), .irq(irq), .adc_trigger(adc));
	gpp_pad_model i_gpp_pad_model (.pad_out(pout), .pad_oe(poe), .pad_cfg(cfg),
		.ext_lvl(ext), .ext_en(exen), .pad_in(pin), .alt_out(aout), .alt_oe(aoe));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// write: address and data offered together, each dropped once taken
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (awv && awr) awv <= 0;
			if (wv && wr) wv <= 0;
		end while (!bv && n < 50);
		brsp = br;
		bry <= 0;
		if (n >= 50) chk("write answer", 1, 0);
		// idle edge so a following call never re-raises a strobe in this step
		@(posedge aclk);
	endtask : wr_reg
	// read: data and response taken at the edge where rvalid is seen
	task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
		int n;
		n = 0;
		ara <= a; arv <= 1; rry <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (arv && arr) arv <= 0;
		end while (!rv && n < 50);
		d = rdat;
		rrsp = rr;
		rry <= 0;
		if (n >= 50) chk("read answer", 1, 0);
		@(posedge aclk);
	endtask : rd_reg
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd_reg(a, d);
		chk(nm, e, d);
	endtask : rchk
	task automatic pins(input logic [7:0] v);
		ext <= v;
		repeat (5) @(posedge aclk);
	endtask : pins
	// watchdog: whole run needs a few hundred cycles
	initial begin
		#200us;
		n_fail++;
		give_verdict();
	end
	initial begin
		logic [11:0] ra [6] = '{gpp_pkg::OFF_DIR, gpp_pkg::OFF_AFS, gpp_pkg::OFF_DRL,
			gpp_pkg::OFF_PUR, gpp_pkg::OFF_DEN, gpp_pkg::OFF_IM};
		logic [7:0] rv0 [6] = '{8'h00, 8'h80, 8'hff, 8'hff, 8'hff, 8'h00};
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		// three clocks before the first access
		repeat (3) @(posedge aclk);
		// reset state of direction, alt select, pad settings and interrupt mask
		foreach (ra[i]) rchk("reset value", ra[i], {24'h0, rv0[i]});
		chk("pad cfg high", 32'hff00_0000, cfg[63:32]);
		chk("pad cfg low", 32'hff00_00ff, cfg[31:0]);
		// masked write then masked reads
		wr_reg(gpp_pkg::OFF_DIR, 32'hff);
		// inputs held the pulled-up pad level; start the example from zero
		wr_reg(12'h3fc, 32'h00);
		wr_reg(12'h098, 32'heb);
		rchk("data all", 12'h3fc, 32'h22);
		rchk("data masked", 12'h0c4, 32'h20);
		repeat (2) @(posedge aclk);
		chk("pad drive", 32'h7f22, {16'h0, poe, pout});
		// inputs capture the pad
		wr_reg(gpp_pkg::OFF_DIR, 32'h00);
		exen <= 8'hff;
		pins(8'h5a);
		rchk("input capture", 12'h1fc, 32'h5a);
		chk("alt in", 32'h5a, {24'h0, ain});
		// rising edge on the trigger pin, latched until cleared
		// trigger settings change only while the pins are masked
		pins(8'h00);
		wr_reg(gpp_pkg::OFF_IEV, 32'h12);
		wr_reg(gpp_pkg::OFF_ICR, 32'hff);
		wr_reg(gpp_pkg::OFF_IM, 32'h10);
		pins(8'h10);
		chk("irq adc", 3, {30'h0, irq, adc});
		pins(8'h00);
		rchk("raw latched", gpp_pkg::OFF_RIS, 32'h10);
		wr_reg(gpp_pkg::OFF_ICR, 32'h00);
		rchk("masked kept", gpp_pkg::OFF_MIS, 32'h10);
		wr_reg(gpp_pkg::OFF_ICR, 32'h10);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 0, {30'h0, irq, adc});
		// masked pin still detected
		pins(8'h02);
		rchk("raw unmasked", gpp_pkg::OFF_RIS, 32'h02);
		rchk("masked none", gpp_pkg::OFF_MIS, 32'h00);
		chk("irq masked", 0, {31'h0, irq});
		// high level on pin 1 follows the pin and ignores clear
		wr_reg(gpp_pkg::OFF_IS, 32'h02);
		wr_reg(gpp_pkg::OFF_ICR, 32'hff);
		wr_reg(gpp_pkg::OFF_IM, 32'h02);
		repeat (2) @(posedge aclk);
		chk("level irq", 1, {31'h0, irq});
		pins(8'h00);
		chk("level gone", 0, {31'h0, irq});
		// unmapped and read-only places
		rchk("unmapped", 12'h600, 32'h0);
		chk("unmapped resp", 2, {30'h0, rrsp});
		wr_reg(12'h600, 32'hff);
		chk("unmapped wresp", 2, {30'h0, brsp});
		wr_reg(gpp_pkg::OFF_RIS, 32'hff);
		chk("readonly wresp", 0, {30'h0, brsp});
		rchk("raw readonly", gpp_pkg::OFF_RIS, 32'h00);
		rchk("ident word", 12'hff4, 32'h0b);
		// a reset in mid-run restores the defaults
		wr_reg(gpp_pkg::OFF_AFS, 32'h01);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		repeat (3) @(posedge aclk);
		rchk("afs after reset", gpp_pkg::OFF_AFS, 32'h80);
		rchk("im after reset", gpp_pkg::OFF_IM, 32'h00);
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
